// *** rtl/arc_defs.vh ***
// constants for the analog regulator control register bank
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH
// documented word offsets are not all multiples of four: byte addr = 4*index
`define ARC_IDX_REG_CTRL     16'hfece
`define ARC_IDX_REG_VOLT     16'hfed0
`define ARC_IDX_ANA_PWR      16'hfecb
`define ARC_IDX_RF_OSC       16'hfed3
`define ARC_IDX_OSC_FRAC_LO  16'hfed7
`define ARC_IDX_OSC_FRAC_HI  16'hfed8
`define ARC_ADDR_W           18
// analog power control fields
`define ARC_AP_SUPPLY_LOW    14
`define ARC_AP_BUTTON        13
`define ARC_AP_BTN_RST_DIS   12
`define ARC_AP_RSV_ONE       11
`define ARC_AP_PRESCALE      10
`define ARC_AP_RF_OSC_EN     9
`define ARC_AP_ADC_EN        8
`define ARC_AP_LEFT_DRV      7
`define ARC_AP_RIGHT_DRV     6
`define ARC_AP_GND_BUF       5
`define ARC_AP_CONV_CORE     4
`define ARC_AP_WR_MASK       16'h1fff
// rf oscillator control fields
`define ARC_RF_MOD_EN        13
`define ARC_RF_LOCK_ST       12
`define ARC_RF_LOCK_CHK      11
`define ARC_RF_WR_MASK       16'h2fff
// regulator control fields
`define ARC_RC_LATCH         3
`define ARC_RC_WR_MASK       16'h000f
`define ARC_RV_WR_MASK       16'h7fff
`define ARC_FRAC_HI_MASK     16'h03ff
`define ARC_RESET_VAL        16'h0000
// gain codes
`define ARC_GAIN_0DB         2'h0
`define ARC_GAIN_M12DB       2'h1
`define ARC_GAIN_M2DB        2'h2
`define ARC_GAIN_M6DB        2'h3
// long press time
`define ARC_LONG_PRESS_MS    5000
`define ARC_CLK_KHZ          125000
`endif

// *** rtl/arc_press_timer.v ***
// power button long-press detector producing a system reset pulse
`timescale 1ns/1ns
module arc_press_timer #(
	parameter LIMIT = 32'd625000000
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        pressed,
	input  wire        disable_rst,
	output reg         sys_reset_q
);
	reg [31:0] cnt_q;

	// counter saturates so one press yields one reset pulse
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q       <= 32'h0;
			sys_reset_q <= 1'b0;
		end else begin
			sys_reset_q <= 1'b0;
			if (!pressed || disable_rst) begin
				cnt_q <= 32'h0;
			end else if (cnt_q < LIMIT) begin
				cnt_q <= cnt_q + 32'h1;
			end else if (cnt_q == LIMIT) begin
				cnt_q       <= cnt_q + 32'h1;
				sys_reset_q <= 1'b1;
			end
		end
	end
endmodule // arc_press_timer

// *** rtl/arc_regs.v ***
// analog regulator control register bank with apb slave
// Overview of operation
// - bit 14 reads one while regulator input supply is below threshold
// - bit 13 returns present power-button level on every read
// - button held over 5 s produces a system reset pulse
// - button reset disable bit 12 blocks the long-press reset
// - prescale bit 10 halves the oscillator clock, else passes through
// - bit 8 powers and enables the 12-bit adc
// - gain codes: 0 is 0 dB, 1 is -12, 3 is -6, avoid 2
// - lock check: set then clear bit 11, read lock status bit 12
// - bit 13 enables the oscillator sigma-delta modulator
// - bit 9 enables the 480 MHz clock driver to usb macro
// - voltage codes and shutdown bits apply only on latch bit 3
// - voltage register holds analog, io and core five-bit codes
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "arc_defs.vh"
module arc_regs #(
	parameter LONG_PRESS_CYC = 32'd625000000
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        supply_low_pin,
	input  wire        button_pin,
	input  wire        osc_lock_pin,
	input  wire        osc_clk_in,
	output reg         osc_clk_out,
	output wire        button_reset,
	output wire        rf_osc_enable,
	output wire        adc_enable,
	output wire        left_driver_enable,
	output wire        right_driver_enable,
	output wire        ground_buffer_enable,
	output wire        converter_core_enable,
	output wire [1:0]  right_gain,
	output wire [1:0]  left_gain,
	output reg  [5:0]  right_atten_db,
	output reg  [5:0]  left_atten_db,
	output wire        modulator_enable,
	output wire        rf_lock_check,
	output wire        usb_pad_bias,
	output wire        hs_clock_driver_enable,
	output wire        usb_transceiver_enable,
	output wire [1:0]  clock_divider_select,
	output wire [1:0]  osc_divider_select,
	output wire [3:0]  center_freq_trim,
	output wire [25:0] osc_fractional_control,
	output reg  [4:0]  analog_voltage_code,
	output reg  [4:0]  io_voltage_code,
	output reg  [4:0]  core_voltage_code,
	output reg         analog_reg_shutdown,
	output reg         io_reg_shutdown,
	output reg         core_reg_shutdown
);
	reg [15:0] ana_pwr_q;
	reg [15:0] rf_osc_q;
	reg [15:0] reg_ctrl_q;
	reg [15:0] reg_volt_q;
	reg [15:0] frac_lo_q;
	reg [15:0] frac_hi_q;
	reg        latch_prev_q;
	reg [1:0]  low_sync_q;
	reg [1:0]  btn_sync_q;
	reg [1:0]  lock_sync_q;
	reg [1:0]  oclk_sync_q;
	reg        oclk_div_q;

	wire [15:0] idx;
	wire        in_range;
	wire        wr;
	wire        latch_rise;

	// word index from byte address; low two bits and high bits must be 0
	assign idx      = paddr[17:2];
	assign in_range = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~(in_range & hit(idx));
	assign wr       = psel & penable & pwrite & in_range;

	function hit;
		input [15:0] a;
		begin
			hit = (a == `ARC_IDX_REG_CTRL) || (a == `ARC_IDX_REG_VOLT) ||
			      (a == `ARC_IDX_ANA_PWR) || (a == `ARC_IDX_RF_OSC) ||
			      (a == `ARC_IDX_OSC_FRAC_LO) ||
			      (a == `ARC_IDX_OSC_FRAC_HI);
		end
	endfunction

	// gain code to attenuation in dB
	function [5:0] atten;
		input [1:0] code;
		begin
			case (code)
				`ARC_GAIN_0DB:   atten = 6'd0;
				`ARC_GAIN_M12DB: atten = 6'd12;
				`ARC_GAIN_M2DB:  atten = 6'd2;
				default:         atten = 6'd6;
			endcase
		end
	endfunction

	// masked write: bits outside mask keep their stored value
	function [15:0] mwr;
		input [15:0] old;
		input [15:0] din;
		input [15:0] mask;
		begin
			mwr = (din & mask) | (old & ~mask);
		end
	endfunction

	// pins cross from the analog side through two flops
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			low_sync_q  <= 2'h0;
			btn_sync_q  <= 2'h0;
			lock_sync_q <= 2'h0;
			oclk_sync_q <= 2'h0;
		end else begin
			low_sync_q  <= {low_sync_q[0], supply_low_pin};
			btn_sync_q  <= {btn_sync_q[0], button_pin};
			lock_sync_q <= {lock_sync_q[0], osc_lock_pin};
			oclk_sync_q <= {oclk_sync_q[0], osc_clk_in};
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ana_pwr_q  <= `ARC_RESET_VAL;
			rf_osc_q   <= `ARC_RESET_VAL;
			reg_ctrl_q <= `ARC_RESET_VAL;
			reg_volt_q <= `ARC_RESET_VAL;
			frac_lo_q  <= `ARC_RESET_VAL;
			frac_hi_q  <= `ARC_RESET_VAL;
		end else if (wr) begin
			case (idx)
				`ARC_IDX_ANA_PWR:
					ana_pwr_q <= mwr(ana_pwr_q, pwdata[15:0],
						`ARC_AP_WR_MASK);
				`ARC_IDX_RF_OSC:
					rf_osc_q <= mwr(rf_osc_q, pwdata[15:0],
						`ARC_RF_WR_MASK);
				`ARC_IDX_REG_CTRL:
					reg_ctrl_q <= pwdata[15:0] & `ARC_RC_WR_MASK;
				`ARC_IDX_REG_VOLT:
					reg_volt_q <= pwdata[15:0] & `ARC_RV_WR_MASK;
				`ARC_IDX_OSC_FRAC_LO:
					frac_lo_q <= pwdata[15:0];
				`ARC_IDX_OSC_FRAC_HI:
					frac_hi_q <= pwdata[15:0] & `ARC_FRAC_HI_MASK;
				default: ;
			endcase
		end
	end

	// rising latch bit copies staged codes to regulators
	assign latch_rise = reg_ctrl_q[`ARC_RC_LATCH] & ~latch_prev_q;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_prev_q        <= 1'b0;
			analog_voltage_code <= 5'h0;
			io_voltage_code     <= 5'h0;
			core_voltage_code   <= 5'h0;
			analog_reg_shutdown <= 1'b0;
			io_reg_shutdown     <= 1'b0;
			core_reg_shutdown   <= 1'b0;
		end else begin
			latch_prev_q <= reg_ctrl_q[`ARC_RC_LATCH];
			if (latch_rise) begin
				analog_voltage_code <= reg_volt_q[14:10];
				io_voltage_code     <= reg_volt_q[9:5];
				core_voltage_code   <= reg_volt_q[4:0];
				analog_reg_shutdown <= reg_ctrl_q[2];
				io_reg_shutdown     <= reg_ctrl_q[1];
				core_reg_shutdown   <= reg_ctrl_q[0];
			end
		end
	end

	// prescaler on the oscillator clock, sampled in clk domain
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			oclk_div_q  <= 1'b0;
			osc_clk_out <= 1'b0;
		end else begin
			// previous synced level, so each input rise is seen once
			oclk_div_q <= oclk_sync_q[1];
			if (ana_pwr_q[`ARC_AP_PRESCALE]) begin
				if (oclk_sync_q[1] & ~oclk_div_q)
					osc_clk_out <= ~osc_clk_out;
				else
					osc_clk_out <= osc_clk_out;
			end else begin
				osc_clk_out <= oclk_sync_q[1];
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			right_atten_db <= 6'd0;
			left_atten_db  <= 6'd0;
		end else begin
			right_atten_db <= atten(ana_pwr_q[3:2]);
			left_atten_db  <= atten(ana_pwr_q[1:0]);
		end
	end

	always @* begin
		prdata = 32'h0;
		case (idx)
			`ARC_IDX_ANA_PWR: begin
				prdata[15:0] = ana_pwr_q;
				prdata[`ARC_AP_SUPPLY_LOW] = low_sync_q[1];
				prdata[`ARC_AP_BUTTON]     = btn_sync_q[1];
			end
			`ARC_IDX_RF_OSC: begin
				prdata[15:0] = rf_osc_q;
				prdata[`ARC_RF_LOCK_ST] = lock_sync_q[1];
			end
			`ARC_IDX_REG_CTRL:    prdata[15:0] = reg_ctrl_q;
			`ARC_IDX_REG_VOLT:    prdata[15:0] = reg_volt_q;
			`ARC_IDX_OSC_FRAC_LO: prdata[15:0] = frac_lo_q;
			`ARC_IDX_OSC_FRAC_HI: prdata[15:0] = frac_hi_q;
			default:              prdata = 32'h0;
		endcase
		if (!in_range)
			prdata = 32'h0;
	end

	assign rf_osc_enable          = ana_pwr_q[`ARC_AP_RF_OSC_EN];
	assign adc_enable             = ana_pwr_q[`ARC_AP_ADC_EN];
	assign left_driver_enable     = ana_pwr_q[`ARC_AP_LEFT_DRV];
	assign right_driver_enable    = ana_pwr_q[`ARC_AP_RIGHT_DRV];
	assign ground_buffer_enable   = ana_pwr_q[`ARC_AP_GND_BUF];
	assign converter_core_enable  = ana_pwr_q[`ARC_AP_CONV_CORE];
	assign right_gain             = ana_pwr_q[3:2];
	assign left_gain              = ana_pwr_q[1:0];
	assign modulator_enable       = rf_osc_q[`ARC_RF_MOD_EN];
	assign rf_lock_check          = rf_osc_q[`ARC_RF_LOCK_CHK];
	assign usb_pad_bias           = rf_osc_q[10];
	assign hs_clock_driver_enable = rf_osc_q[9];
	assign usb_transceiver_enable = rf_osc_q[8];
	assign clock_divider_select   = rf_osc_q[7:6];
	assign osc_divider_select     = rf_osc_q[5:4];
	assign center_freq_trim       = rf_osc_q[3:0];
	assign osc_fractional_control = {frac_hi_q[9:0], frac_lo_q};

	arc_press_timer #(
		.LIMIT (LONG_PRESS_CYC)
	) u_press (
		.clk         (clk),
		.rst         (rst),
		.pressed     (btn_sync_q[1]),
		.disable_rst (ana_pwr_q[`ARC_AP_BTN_RST_DIS]),
		.sys_reset_q (button_reset)
	);
endmodule // arc_regs

// *** test/arc_regs_asserts.sv ***
// port assertions for the analog regulator control register bank
`timescale 1ns/1ns
`include "arc_defs.vh"
module arc_regs_asserts (
	input logic        clk, rst, psel, penable, pwrite, pready, pslverr,
	input logic [31:0] paddr, pwdata,
	input logic        button_pin, button_reset, adc_enable, modulator_enable,
	input logic [1:0]  right_gain, left_gain,
	input logic [5:0]  right_atten_db, left_atten_db,
	input logic [4:0]  analog_voltage_code, core_voltage_code
);
	localparam [31:0] A_AP = 4 * `ARC_IDX_ANA_PWR;
	localparam [31:0] A_RF = 4 * `ARC_IDX_RF_OSC;
	localparam [31:0] A_RC = 4 * `ARC_IDX_REG_CTRL;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire wr    = psel && penable && pwrite;
	wire latch = wr && paddr == A_RC && pwdata[3];
	function automatic logic [5:0] att(input logic [1:0] c);
		return c == 2'h1 ? 6'h0c : c == 2'h2 ? 6'h02 : c == 2'h3 ? 6'h06 : 6'h00;
	endfunction
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access not answered");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_pulse; button_reset |=> !button_reset; endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	property p_held; button_reset |-> $past(button_pin, 8); endproperty
	a_held: assert property (p_held) else $error("reset without press");
	property p_adc; $changed(adc_enable) |-> $past(wr && paddr == A_AP); endproperty
	a_adc: assert property (p_adc) else $error("adc enable moved alone");
	property p_mod;
		$changed(modulator_enable) |-> $past(wr && paddr == A_RF);
	endproperty
	a_mod: assert property (p_mod) else $error("modulator moved alone");
	property p_ratt; $stable(right_gain) |-> right_atten_db == att(right_gain); endproperty
	a_ratt: assert property (p_ratt) else $error("right gain decode");
	property p_latt; $stable(left_gain) |-> left_atten_db == att(left_gain); endproperty
	a_latt: assert property (p_latt) else $error("left gain decode");
	// latch lag allowed one to three edges
	property p_volt;
		$changed(analog_voltage_code) |-> $past(latch) || $past(latch, 2) || $past(latch, 3);
	endproperty
	a_volt: assert property (p_volt) else $error("analog code unlatched");
	property p_core;
		$changed(core_voltage_code) |-> $past(latch) || $past(latch, 2) || $past(latch, 3);
	endproperty
	a_core: assert property (p_core) else $error("core code unlatched");
endmodule // arc_regs_asserts
bind arc_regs arc_regs_asserts u_chk (.clk, .rst, .psel, .penable, .pwrite,
	.pready, .pslverr, .paddr, .pwdata, .button_pin, .button_reset, .adc_enable,
	.modulator_enable, .right_gain, .left_gain, .right_atten_db, .left_atten_db,
	.analog_voltage_code, .core_voltage_code);

// *** test/arc_regs_tb.sv ***
// self-checking bench for the analog regulator control register bank
`timescale 1ns/1ns
`include "arc_defs.vh"
module arc_regs_tb;
	localparam [31:0] A_AP = 4 * `ARC_IDX_ANA_PWR;
	localparam [31:0] A_RF = 4 * `ARC_IDX_RF_OSC;
	localparam [31:0] A_RC = 4 * `ARC_IDX_REG_CTRL;
	localparam [31:0] A_RV = 4 * `ARC_IDX_REG_VOLT;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [31:0] paddr = '0, pwdata = '0, q;
	logic supply_low_pin = 0, button_pin = 0, osc_lock_pin = 0, osc_clk_in = 0;
	wire pready, pslverr, osc_clk_out, button_reset, adc_enable, modulator_enable;
	wire rf_lock_check, analog_reg_shutdown, io_reg_shutdown, core_reg_shutdown;
	wire [1:0] right_gain, left_gain, clock_divider_select, osc_divider_select;
	wire rf_osc_enable, left_driver_enable, right_driver_enable;
	wire ground_buffer_enable, converter_core_enable, usb_pad_bias;
	wire hs_clock_driver_enable, usb_transceiver_enable;
	wire [3:0] center_freq_trim;
	wire [31:0] prdata;
	wire [5:0] right_atten_db, left_atten_db;
	wire [4:0] analog_voltage_code, io_voltage_code, core_voltage_code;
	int mismatches = 0, n_tests = 0, n_rst = 0, n_osc = 0;
	logic [5:0] tbl [4] = '{6'h00, 6'h0c, 6'h02, 6'h06};
	// long press shortened to keep the run small
	arc_regs #(.LONG_PRESS_CYC(32'd50)) u_dut (.clk, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .supply_low_pin,
		.button_pin, .osc_lock_pin, .osc_clk_in, .osc_clk_out, .button_reset,
		.rf_osc_enable, .adc_enable, .left_driver_enable,
		.right_driver_enable, .ground_buffer_enable,
		.converter_core_enable, .right_gain, .left_gain, .right_atten_db,
		.left_atten_db, .modulator_enable, .rf_lock_check, .usb_pad_bias,
		.hs_clock_driver_enable, .usb_transceiver_enable,
		.clock_divider_select, .osc_divider_select, .center_freq_trim,
		.osc_fractional_control(), .analog_voltage_code, .io_voltage_code,
		.core_voltage_code, .analog_reg_shutdown, .io_reg_shutdown,
		.core_reg_shutdown);
	initial forever #4 clk = ~clk;
	// slow oscillator so the sampled divider can follow it
	initial forever begin
		repeat (10) @(posedge clk);
		osc_clk_in <= ~osc_clk_in;
	end
	always @(posedge osc_clk_out) n_osc++;
	always @(posedge clk) if (button_reset === 1'b1) n_rst++;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 64);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		// let the register update settle before outputs are compared
		@(negedge clk);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	initial begin
		#(8 * 20000);
		mismatches++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		rd(A_AP, 32'h0);
		rd(A_RF, 32'h0);
		rd(A_RC, 32'h0);
		rd(A_RV, 32'h0);
		wr(A_AP, 32'hffff);
		rd(A_AP, 32'h1fff);
		chk(adc_enable, 1);
		supply_low_pin <= 1;
		button_pin <= 1;
		repeat (4) @(posedge clk);
		rd(A_AP, 32'h7fff);
		repeat (80) @(posedge clk);
		chk(n_rst, 0);
		button_pin <= 0;
		supply_low_pin <= 0;
		wr(A_AP, 32'h0);
		repeat (4) @(posedge clk);
		button_pin <= 1;
		repeat (70) @(posedge clk);
		chk(n_rst, 1);
		button_pin <= 0;
		for (int i = 0; i < 4; i++) begin
			wr(A_AP, 32'(((3 - i) << 2) | i));
			repeat (3) @(posedge clk);
			chk(left_atten_db, tbl[i]);
			chk(right_atten_db, tbl[3 - i]);
		end
		wr(A_AP, 32'h0);
		n_osc = 0;
		repeat (400) @(posedge clk);
		chk(n_osc >= 19 && n_osc <= 21, 1);
		wr(A_AP, 32'h0400);
		n_osc = 0;
		repeat (400) @(posedge clk);
		chk(n_osc >= 9 && n_osc <= 11, 1);
		wr(A_RF, 32'h3fff);
		rd(A_RF, 32'h2fff);
		chk(modulator_enable, 1);
		osc_lock_pin <= 1;
		wr(A_RF, 32'h0800);
		chk(rf_lock_check, 1);
		wr(A_RF, 32'h0);
		repeat (3) @(posedge clk);
		rd(A_RF, 32'h1000);
		wr(A_RV, 32'h7fff);
		rd(A_RV, 32'h7fff);
		wr(A_RC, 32'h7);
		repeat (3) @(posedge clk);
		chk({analog_voltage_code, io_voltage_code, core_voltage_code,
			analog_reg_shutdown, io_reg_shutdown, core_reg_shutdown}, 0);
		wr(A_RC, 32'hf);
		repeat (3) @(posedge clk);
		chk({analog_voltage_code, io_voltage_code, core_voltage_code,
			analog_reg_shutdown, io_reg_shutdown, core_reg_shutdown}, 32'h3ffff);
		// latch is edge driven: clear then set again
		wr(A_RV, 32'h2a46);
		wr(A_RC, 32'h0);
		wr(A_RC, 32'h8);
		repeat (3) @(posedge clk);
		chk({analog_voltage_code, io_voltage_code, core_voltage_code,
			analog_reg_shutdown, io_reg_shutdown, core_reg_shutdown}, 32'h15230);
		wr(A_AP, 32'h02f0);
		chk({rf_osc_enable, left_driver_enable, right_driver_enable,
			ground_buffer_enable, converter_core_enable}, 32'h1f);
		for (int t = 0; t < 3; t++) begin
			osc_lock_pin <= (t == 2);
			wr(A_RF, 32'h0f00 | t);
			wr(A_RF, 32'h0700 | t);
			rd(A_RF, 32'h0700 | t | ((t == 2) << 12));
		end
		chk({usb_pad_bias, hs_clock_driver_enable, usb_transceiver_enable,
			clock_divider_select, osc_divider_select,
			center_freq_trim}, 32'h702);
		xfer(1'b0, 32'h0, 32'h0);
		chk(err, 1);
		chk(q, 0);
		finish_test();
	end
endmodule // arc_regs_tb
